// file: reset_watchdog_pkg.sv
// Purpose: constants, types and helpers of the reset controller and its watchdog
// Assumes: 200 MHz core clock, 128 kHz watchdog oscillator on a pin
// Notes: bus offsets are byte addresses of aligned 32-bit words
package reset_watchdog_pkg;
    // register map, byte offsets
    localparam logic [7:0] CAUSE_OFS = 8'h00;
    localparam logic [7:0] WDCTRL_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    // status register bit positions
    localparam int STAT_BANDGAP_BIT = 0;
    localparam int STAT_WINDOW_BIT = 1;
    localparam int STAT_BROWNOUT_EN_BIT = 2;
    // clock and timing
    localparam int CLK_MHZ = 200;
    localparam int EXT_MIN_PULSE_NS = 2500;
    localparam int EXT_MIN_CYC = (EXT_MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int BROWNOUT_MIN_LOW_NS = 2000;
    localparam int BROWNOUT_MIN_CYC = (BROWNOUT_MIN_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int RELEASE_DELAY_BASE_CYC = 64;
    localparam int CHANGE_WINDOW_CYC = 4;
    localparam int WDOG_OSC_KHZ = 128;
    localparam int WDOG_MIN_PERIOD_MS = 16;
    localparam int WDOG_MIN_TICKS = WDOG_MIN_PERIOD_MS * WDOG_OSC_KHZ;
    localparam int WDOG_MAX_SEL = 9;
    localparam logic [2:0] BROWNOUT_OFF_CODE = 3'h7;
    // watchdog control word, bit 7 down to bit 0
    typedef struct packed {
        logic watchdog_interrupt_flag;
        logic watchdog_interrupt_enable;
        logic period_sel_hi;
        logic change_enable;
        logic reset_enable;
        logic [2:0] period_sel_lo;
    } wdog_ctrl_t;
    // reset cause flags, bit 3 down to bit 0
    typedef struct packed {
        logic watchdog_reset_cause_flag;
        logic brownout_flag;
        logic external_flag;
        logic poweron_flag;
    } cause_t;
    localparam wdog_ctrl_t WDCTRL_RESET = 8'h00;
    localparam cause_t CAUSE_RESET = 4'h0;
    // a level is accepted once the second and third synchroniser stages agree
    function automatic logic settle(input logic cur, input logic s2, input logic s3);
        settle = (s2 == s3) ? s3 : cur;
    endfunction
endpackage

// file: watchdog_counter.sv
// Purpose: watchdog period counter on ticks of the watchdog oscillator pin
// Assumes: oscillator much slower than the core clock
// Notes: expire is a one-cycle pulse in the core clock domain
`timescale 1ns/1ps
module watchdog_counter #(
    parameter int MIN_TICKS = reset_watchdog_pkg::WDOG_MIN_TICKS,
    parameter int MAX_SEL = reset_watchdog_pkg::WDOG_MAX_SEL
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic osc,
    input wire logic run,
    input wire logic restart,
    input wire logic [3:0] sel,
    output logic expire
);
    localparam int CW = $clog2(MIN_TICKS) + MAX_SEL + 1;
    logic [2:0] osc_sy;
    logic osc_lvl;
    logic tick;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] limit;
    logic [3:0] sel_c;

    if (MIN_TICKS < 2 || MAX_SEL > 15)
        $error("watchdog_counter: unsupported period parameters");

    // three-stage synchroniser, only the settled level is looked at
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            osc_sy <= 3'h0;
            osc_lvl <= 1'b0;
        end
        else
        begin
            osc_sy <= {osc_sy[1:0], osc};
            osc_lvl <= reset_watchdog_pkg::settle(osc_lvl, osc_sy[1], osc_sy[2]);
        end
    end

    // one oscillator cycle counted per settled rising change
    assign tick = !osc_lvl && reset_watchdog_pkg::settle(osc_lvl, osc_sy[1], osc_sy[2]);
    // reserved selector codes clamp to the longest period
    assign sel_c = (sel > 4'(MAX_SEL)) ? 4'(MAX_SEL) : sel;
    assign limit = CW'(MIN_TICKS) << sel_c;

    // period counter; restart clears it so a timely restart never expires
    always_ff @(posedge clk)
    begin
        if (rst || restart || !run)
        begin
            cnt_reg <= '0;
            expire <= 1'b0;
        end
        else if (tick && cnt_reg == limit - CW'(1))
        begin
            cnt_reg <= '0;
            expire <= 1'b1;
        end
        else
        begin
            cnt_reg <= tick ? cnt_reg + CW'(1) : cnt_reg;
            expire <= 1'b0;
        end
    end

    restart_clears_a: assert property (@(posedge clk) disable iff (rst)
        restart |=> cnt_reg == '0 && !expire)
        else $error("watchdog count not cleared by restart");
    expire_on_tick_a: assert property (@(posedge clk) disable iff (rst)
        expire |-> $past(tick) && $past(run))
        else $error("watchdog expired without an oscillator tick");
endmodule

// file: reset_control_with_watchdog.sv
// Purpose: merges four reset sources, stretches the reset, hosts the watchdog
// Assumes: AHB-Lite slave with single word transfers; fuses are static
// Notes: cause flags survive the stretched reset; only RESETN clears the bus
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module reset_control_with_watchdog #(
    parameter int EXT_CYC = reset_watchdog_pkg::EXT_MIN_CYC,
    parameter int BROWNOUT_CYC = reset_watchdog_pkg::BROWNOUT_MIN_CYC,
    parameter int DELAY_BASE = reset_watchdog_pkg::RELEASE_DELAY_BASE_CYC,
    parameter int WD_MIN_TICKS = reset_watchdog_pkg::WDOG_MIN_TICKS
) (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic POWERON_LOW,
    input wire logic EXT_RESET_N,
    input wire logic BROWNOUT_LOW,
    input wire logic [2:0] BROWNOUT_LEVEL_FUSES,
    input wire logic RESET_PIN_DISABLE_FUSE,
    input wire logic WATCHDOG_ALWAYS_ON_FUSE,
    input wire logic [1:0] STARTUP_TIME_SELECT_FUSE,
    input wire logic [3:0] CLOCK_SOURCE_SELECT_FUSE,
    input wire logic COMPARATOR_BANDGAP_SELECT,
    input wire logic CONVERTER_ENABLE,
    input wire logic WDOG_OSC,
    input wire logic WDOG_RESTART,
    input wire logic WDOG_VECTOR_TAKEN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic SYS_RESET_N,
    output logic FETCH_START,
    output logic WDOG_IRQ,
    output logic BANDGAP_ENABLE
);
    localparam int DW = 16;
    logic [2:0] pwr_sy, ext_sy, bo_sy;
    logic pwr_set, ext_set, bo_set;
    logic [DW-1:0] ext_cnt, bo_cnt, dly_cnt;
    logic ext_active, bo_active;
    logic brownout_en;
    logic async_src, any_src;
    logic held_reg;
    logic [DW-1:0] dly_target;
    logic wd_pulse_reg;
    logic expire;
    logic rst_int;
    reset_watchdog_pkg::cause_t cause_reg, cause_next;
    reset_watchdog_pkg::wdog_ctrl_t wdc_reg, wdc_next, wr_val;
    logic [2:0] win_cnt;
    logic win_open;
    logic dp_wr_reg, dp_rd_reg;
    logic [7:0] dp_addr_reg;
    logic ap;
    logic wr_wd, wr_cause;
    logic [31:0] rd_word;

    // the largest base must still fit the 16-bit stretch counter after a shift of six
    if (EXT_CYC < 1 || BROWNOUT_CYC < 1 || DELAY_BASE < 1 || DELAY_BASE > 512)
        $error("reset_control_with_watchdog: unsupported timing parameters");

    // pin and analog levels pass three stages before use
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
        begin
            pwr_sy <= 3'h7;
            ext_sy <= 3'h7;
            bo_sy <= 3'h0;
            pwr_set <= 1'b1;
            ext_set <= 1'b1;
            bo_set <= 1'b0;
        end
        else
        begin
            pwr_sy <= {pwr_sy[1:0], POWERON_LOW};
            ext_sy <= {ext_sy[1:0], EXT_RESET_N};
            bo_sy <= {bo_sy[1:0], BROWNOUT_LOW};
            pwr_set <= reset_watchdog_pkg::settle(pwr_set, pwr_sy[1], pwr_sy[2]);
            ext_set <= reset_watchdog_pkg::settle(ext_set, ext_sy[1], ext_sy[2]);
            bo_set <= reset_watchdog_pkg::settle(bo_set, bo_sy[1], bo_sy[2]);
        end
    end

    // external pin low must last the minimum pulse before it counts
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN || RESET_PIN_DISABLE_FUSE || ext_set)
        begin
            ext_cnt <= '0;
            ext_active <= 1'b0;
        end
        else if (ext_cnt == DW'(EXT_CYC - 1))
            ext_active <= 1'b1;
        else
            ext_cnt <= ext_cnt + DW'(1);
    end

    assign brownout_en = BROWNOUT_LEVEL_FUSES != reset_watchdog_pkg::BROWNOUT_OFF_CODE;

    // brown-out low filtered against glitches shorter than the minimum time
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN || !brownout_en || !bo_set)
        begin
            bo_cnt <= '0;
            bo_active <= 1'b0;
        end
        else if (bo_cnt == DW'(BROWNOUT_CYC - 1))
            bo_active <= 1'b1;
        else
            bo_cnt <= bo_cnt + DW'(1);
    end

    assign any_src = pwr_set || ext_active || bo_active || wd_pulse_reg;
    // raw pins only; brown-out stays filtered so glitches cannot reach the ports
    assign async_src = POWERON_LOW || (!EXT_RESET_N && !RESET_PIN_DISABLE_FUSE);
    // fuse-selected stretch, base count doubled per selector step;
    // the shift sum is kept at three bits so the largest selection cannot wrap
    assign dly_target = DW'(DELAY_BASE)
        << ({1'b0, STARTUP_TIME_SELECT_FUSE} + {1'b0, CLOCK_SOURCE_SELECT_FUSE[1:0]});

    // delay counter restarts whenever any source is active, counts once all are gone
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN || any_src)
        begin
            held_reg <= 1'b1;
            dly_cnt <= '0;
        end
        else if (held_reg && dly_cnt == dly_target - DW'(1))
            held_reg <= 1'b0;
        else if (held_reg)
            dly_cnt <= dly_cnt + DW'(1);
    end

    // system reset drops asynchronously from pins, releases on the clock
    always_ff @(posedge CORE_CLK or posedge async_src)
    begin
        if (async_src)
            SYS_RESET_N <= 1'b0;
        else
            SYS_RESET_N <= RESETN && !held_reg && !any_src;
    end

    // one pulse as the core leaves reset, telling it to fetch at the reset vector
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            FETCH_START <= 1'b0;
        else
            FETCH_START <= !SYS_RESET_N && !held_reg && !any_src && !async_src;
    end

    assign rst_int = !RESETN || held_reg;

    // AHB-Lite slave: writes take no wait, reads one wait so a preceding write lands
    assign ap = HSEL && HTRANS[1] && HREADY;
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
        begin
            dp_wr_reg <= 1'b0;
            dp_rd_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
            HREADYOUT <= 1'b1;
            HRDATA <= 32'h00000000;
            HRESP <= 1'b0;
        end
        else
        begin
            dp_wr_reg <= ap && HWRITE;
            dp_rd_reg <= ap && !HWRITE;
            dp_addr_reg <= ap ? HADDR[7:0] : dp_addr_reg;
            HREADYOUT <= !(ap && !HWRITE);
            HRDATA <= dp_rd_reg ? rd_word : HRDATA;
            HRESP <= 1'b0;
        end
    end

    assign wr_wd = dp_wr_reg && dp_addr_reg == reset_watchdog_pkg::WDCTRL_OFS;
    assign wr_cause = dp_wr_reg && dp_addr_reg == reset_watchdog_pkg::CAUSE_OFS;
    assign wr_val = HWDATA[7:0];
    assign win_open = win_cnt != 3'h0;

    // read mux; unmapped offsets read zero
    always_comb
    begin
        rd_word = 32'h00000000;
        unique case (dp_addr_reg)
            reset_watchdog_pkg::CAUSE_OFS: rd_word[3:0] = cause_reg;
            reset_watchdog_pkg::WDCTRL_OFS:
            begin
                rd_word[7:0] = wdc_reg;
                rd_word[4] = win_open;
            end
            reset_watchdog_pkg::STATUS_OFS:
            begin
                rd_word[reset_watchdog_pkg::STAT_BANDGAP_BIT] = BANDGAP_ENABLE;
                rd_word[reset_watchdog_pkg::STAT_WINDOW_BIT] = win_open;
                rd_word[reset_watchdog_pkg::STAT_BROWNOUT_EN_BIT] = brownout_en;
            end
            default: rd_word = 32'h00000000;
        endcase
    end

    // cause flags: writing zero clears, a source set in the same cycle wins
    always_comb
    begin
        cause_next = cause_reg;
        if (wr_cause)
            cause_next = cause_reg & HWDATA[3:0];
        cause_next.external_flag = cause_next.external_flag || ext_active;
        cause_next.brownout_flag = cause_next.brownout_flag || bo_active;
        cause_next.watchdog_reset_cause_flag = cause_next.watchdog_reset_cause_flag || wd_pulse_reg;
        if (pwr_set)
            cause_next = 4'h1;
    end

    // flags live through the stretched reset so software can read the cause
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            cause_reg <= reset_watchdog_pkg::CAUSE_RESET;
        else
            cause_reg <= cause_next;
    end

    // change window opened by change enable plus reset enable, closes by itself
    always_ff @(posedge CORE_CLK)
    begin
        if (rst_int)
            win_cnt <= 3'h0;
        else if (wr_wd && wr_val.change_enable && wr_val.reset_enable)
            win_cnt <= 3'(reset_watchdog_pkg::CHANGE_WINDOW_CYC);
        else if (wr_wd && win_open)
            win_cnt <= 3'h0;
        else if (win_open)
            win_cnt <= win_cnt - 3'h1;
    end

    // watchdog control next value; hardware sets win over clears
    always_comb
    begin
        wdc_next = wdc_reg;
        if (wr_wd)
        begin
            wdc_next.watchdog_interrupt_enable = wr_val.watchdog_interrupt_enable;
            if (wr_val.watchdog_interrupt_flag)
                wdc_next.watchdog_interrupt_flag = 1'b0;
            if (wr_val.reset_enable)
                wdc_next.reset_enable = 1'b1;
            if (win_open && !wr_val.change_enable)
            begin
                wdc_next.reset_enable = wr_val.reset_enable;
                wdc_next.period_sel_hi = wr_val.period_sel_hi;
                wdc_next.period_sel_lo = wr_val.period_sel_lo;
            end
        end
        if (WDOG_VECTOR_TAKEN)
        begin
            wdc_next.watchdog_interrupt_flag = 1'b0;
            if (wdc_reg.reset_enable)
                wdc_next.watchdog_interrupt_enable = 1'b0;
        end
        if (expire && wdc_reg.watchdog_interrupt_enable)
        begin
            wdc_next.watchdog_interrupt_flag = 1'b1;
            if (wdc_reg.reset_enable)
                wdc_next.watchdog_interrupt_enable = 1'b0;
        end
        wdc_next.change_enable = 1'b0;
        if (WATCHDOG_ALWAYS_ON_FUSE)
        begin
            wdc_next.reset_enable = 1'b1;
            wdc_next.watchdog_interrupt_enable = 1'b0;
        end
    end

    // reset keeps the watchdog enabled after a watchdog reset, avoiding silent loss
    always_ff @(posedge CORE_CLK)
    begin
        if (rst_int)
        begin
            wdc_reg <= reset_watchdog_pkg::WDCTRL_RESET;
            wdc_reg.reset_enable <= WATCHDOG_ALWAYS_ON_FUSE || cause_reg.watchdog_reset_cause_flag;
        end
        else
            wdc_reg <= wdc_next;
    end

    // one-cycle system reset pulse on expiry in reset mode
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            wd_pulse_reg <= 1'b0;
        else
            wd_pulse_reg <= expire && wdc_reg.reset_enable && !wdc_reg.watchdog_interrupt_enable;
    end

    // level request, valid with the core clock stopped in sleep as long as it runs here
    assign WDOG_IRQ = wdc_reg.watchdog_interrupt_flag;

    // reference kept on only while some user needs it
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            BANDGAP_ENABLE <= 1'b0;
        else
            BANDGAP_ENABLE <= brownout_en || COMPARATOR_BANDGAP_SELECT || CONVERTER_ENABLE;
    end

    watchdog_counter #(
        .MIN_TICKS(WD_MIN_TICKS),
        .MAX_SEL(reset_watchdog_pkg::WDOG_MAX_SEL)
    ) u_counter (
        .clk(CORE_CLK),
        .rst(rst_int),
        .osc(WDOG_OSC),
        .run(wdc_reg.reset_enable || wdc_reg.watchdog_interrupt_enable),
        .restart(WDOG_RESTART),
        .sel({wdc_reg.period_sel_hi, wdc_reg.period_sel_lo}),
        .expire(expire)
    );

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    vector_fetch_a: assert property ($rose(SYS_RESET_N) |-> FETCH_START)
        else $error("no fetch pulse at reset release");
    async_port_reset_a: assert property (POWERON_LOW && $past(POWERON_LOW) |-> !SYS_RESET_N)
        else $error("ports not held in reset by power-on");
    stretch_hold_a: assert property (held_reg && dly_cnt < dly_target - DW'(1) |=> held_reg)
        else $error("internal reset released before the delay ended");
    source_merge_a: assert property (any_src |=> held_reg && !SYS_RESET_N)
        else $error("active source did not hold reset");
    ext_min_pulse_a: assert property ($rose(ext_active) |-> $past(ext_cnt) == DW'(EXT_CYC - 1))
        else $error("external reset accepted before minimum width");
    pin_disabled_a: assert property ($past(RESET_PIN_DISABLE_FUSE) |-> !ext_active)
        else $error("disabled reset pin still resets");
    poweron_hold_a: assert property (pwr_set |=> held_reg && cause_reg == 4'h1)
        else $error("power-on did not reset or set its flag");
    brownout_filter_a: assert property ($rose(bo_active) |-> $past(bo_set, 2))
        else $error("brown-out accepted without persistence");
    wd_pulse_width_a: assert property (wd_pulse_reg |=> !wd_pulse_reg ##1 held_reg)
        else $error("watchdog reset pulse not one cycle");
    bandgap_a: assert property (!brownout_en && !COMPARATOR_BANDGAP_SELECT && !CONVERTER_ENABLE
        |=> !BANDGAP_ENABLE)
        else $error("bandgap on with no user");
    combined_mode_a: assert property (expire && !any_src && !held_reg
        && wdc_reg.watchdog_interrupt_enable && wdc_reg.reset_enable
        |=> WDOG_IRQ && !wdc_reg.watchdog_interrupt_enable)
        else $error("combined mode did not switch to reset mode");
    always_on_a: assert property ($past(WATCHDOG_ALWAYS_ON_FUSE) && WATCHDOG_ALWAYS_ON_FUSE
        |-> wdc_reg.reset_enable && !wdc_reg.watchdog_interrupt_enable)
        else $error("always-on fuse not forcing reset mode");
    protect_a: assert property (wr_wd && !win_open && wdc_reg.reset_enable && !any_src && !held_reg
        |=> wdc_reg.reset_enable)
        else $error("reset enable cleared outside the window");
    window_close_a: assert property (wr_wd && wr_val.change_enable && wr_val.reset_enable
        && !any_src && !held_reg |=> win_open ##4 !win_open)
        else $error("change window length wrong");
    vector_clear_a: assert property (WDOG_VECTOR_TAKEN && !expire && !any_src && !held_reg
        |=> !WDOG_IRQ)
        else $error("vector did not clear the flag");

    wd_reset_c: cover property (wd_pulse_reg ##[1:1000] SYS_RESET_N);
    ext_release_c: cover property (ext_active ##1 !ext_active ##[1:1000] FETCH_START);
    combined_c: cover property (WDOG_IRQ ##[1:1000] wd_pulse_reg);
endmodule

// file: core_model.sv
// Purpose: core side of the watchdog: slow oscillator and restart pulses
// Assumes: oscillator half period of 8 core cycles
// Notes: restart is one cycle per kick request
`timescale 1ns/1ps
module core_model (
    input wire logic clk,
    input wire logic kick,
    output logic osc,
    output logic restart
);
    logic [2:0] div_reg = 3'h0;
    logic osc_reg = 1'b0;
    logic rs_reg = 1'b0;
    // free-running divider toggled on core clock edges, never stopped by kick
    always @(posedge clk)
    begin
        div_reg <= div_reg + 3'h1;
        if (div_reg == 3'h7)
            osc_reg <= ~osc_reg;
        rs_reg <= kick;
    end
    assign osc = osc_reg;
    assign restart = rs_reg;
endmodule

// file: tb_reset_control_with_watchdog.sv
// Purpose: bus-level tests of the reset merger and watchdog
// Assumes: shortened counts, 8-cycle oscillator half period
// Notes: watchdog tests wait out expiries of the 64-cycle shortest period
`timescale 1ns/1ps
module tb_reset_control_with_watchdog;
    logic clk = 1'b0, rstn = 1'b0, por = 1'b1, extn = 1'b1, kick = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, cmp = 1'b1, conv = 1'b0;
    logic bol = 1'b0, pdis = 1'b0, aon = 1'b0, vec = 1'b0;
    logic [2:0] bofuse = 3'h7;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic hrdy, srn, fs, irq, bg, osc, restart, hresp;
    int n_errors = 0, num_checks = 0, cyc = 0;
    core_model core_u (.clk(clk), .kick(kick), .osc(osc), .restart(restart));
    reset_control_with_watchdog #(.EXT_CYC(4), .BROWNOUT_CYC(4), .DELAY_BASE(2),
        .WD_MIN_TICKS(4)) dut_u (.CORE_CLK(clk), .RESETN(rstn), .POWERON_LOW(por),
        .EXT_RESET_N(extn), .BROWNOUT_LOW(bol), .BROWNOUT_LEVEL_FUSES(bofuse),
        .RESET_PIN_DISABLE_FUSE(pdis), .WATCHDOG_ALWAYS_ON_FUSE(aon),
        .STARTUP_TIME_SELECT_FUSE(2'h0), .CLOCK_SOURCE_SELECT_FUSE(4'h0),
        .COMPARATOR_BANDGAP_SELECT(cmp), .CONVERTER_ENABLE(conv), .WDOG_OSC(osc),
        .WDOG_RESTART(restart), .WDOG_VECTOR_TAKEN(vec), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .SYS_RESET_N(srn),
        .FETCH_START(fs), .WDOG_IRQ(irq), .BANDGAP_ENABLE(bg));
    always #2.5 clk = ~clk;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // a hang counts against the run instead of stalling it
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // one single AHB-Lite transfer; waits on HREADYOUT in both phases
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
        bus(1'b0, a, 32'h0);
        chk(q, e, m);
    endtask
    // bounded wait for the reset output (0) or the interrupt (1) to reach v
    task automatic wt(input bit s, input logic v);
        int k;
        k = 0;
        while ((s ? irq : srn) !== v && k < 400)
        begin
            @(posedge clk);
            k++;
        end
    endtask
    task automatic rel();
        wt(1'b0, 1'b1);
        chk(fs, 1'b1, "fetch start at release");
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        chk(srn, 1'b0, "held by power-on");
        por <= 1'b0;
        rel();
        rd(8'h00, 32'h1, "power-on cause");
        bus(1'b1, 8'h00, 32'h0);
        rd(8'h00, 32'h0, "cause cleared by zero");
        chk(bg, 1'b1, "bandgap for comparator");
        cmp <= 1'b0;
        repeat (3) @(posedge clk);
        chk(bg, 1'b0, "bandgap off");
        conv <= 1'b1;
        repeat (3) @(posedge clk);
        chk(bg, 1'b1, "bandgap for converter");
        conv <= 1'b0;
        chk(hresp, 1'b0, "response okay");
        $display("test power and bandgap done");
        extn <= 1'b0;
        @(posedge clk);
        #1 chk(srn, 1'b0, "pin reset without delay");
        repeat (12) @(posedge clk);
        extn <= 1'b1;
        rel();
        rd(8'h00, 32'h2, "external cause");
        bus(1'b1, 8'h00, 32'h0);
        $display("test external done");
        pdis <= 1'b1;
        @(posedge clk);
        extn <= 1'b0;
        repeat (12) @(posedge clk);
        chk(srn, 1'b1, "disabled pin ignored");
        extn <= 1'b1;
        repeat (6) @(posedge clk);
        pdis <= 1'b0;
        rd(8'h00, 32'h0, "no external cause");
        $display("test pin disable done");
        bofuse <= 3'h0;
        repeat (2) @(posedge clk);
        chk(bg, 1'b1, "bandgap for brown-out");
        bol <= 1'b1;
        repeat (2) @(posedge clk);
        bol <= 1'b0;
        repeat (10) @(posedge clk);
        chk(srn, 1'b1, "brown-out glitch filtered");
        bol <= 1'b1;
        wt(1'b0, 1'b0);
        chk(srn, 1'b0, "brown-out reset");
        bol <= 1'b0;
        rel();
        rd(8'h00, 32'h4, "brown-out cause");
        bus(1'b1, 8'h00, 32'h0);
        bofuse <= 3'h7;
        $display("test brown-out done");
        bus(1'b1, 8'h04, 32'h40);
        wt(1'b1, 1'b1);
        chk(irq, 1'b1, "interrupt on expiry");
        bus(1'b1, 8'h04, 32'hC0);
        @(posedge clk);
        chk(irq, 1'b0, "flag cleared by one");
        wt(1'b1, 1'b1);
        vec <= 1'b1;
        @(posedge clk);
        vec <= 1'b0;
        @(posedge clk);
        chk(irq, 1'b0, "flag cleared by vector");
        bus(1'b1, 8'h04, 32'h0);
        $display("test interrupt done");
        bus(1'b1, 8'h04, 32'h08);
        wt(1'b0, 1'b0);
        chk(srn, 1'b0, "watchdog reset");
        rel();
        rd(8'h00, 32'h8, "watchdog cause");
        bus(1'b1, 8'h00, 32'h0);
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        bus(1'b1, 8'h04, 32'h18);
        repeat (6) @(posedge clk);
        bus(1'b1, 8'h04, 32'h00);
        rd(8'h04, 32'h08, "late write refused");
        bus(1'b1, 8'h04, 32'h18);
        bus(1'b1, 8'h04, 32'h00);
        rd(8'h04, 32'h00, "timed clear taken");
        $display("test watchdog reset done");
        bus(1'b1, 8'h04, 32'h48);
        wt(1'b1, 1'b1);
        chk(irq, 1'b1, "combined first expiry interrupts");
        rd(8'h04, 32'h88, "combined mode now reset only");
        vec <= 1'b1;
        @(posedge clk);
        vec <= 1'b0;
        @(posedge clk);
        chk(irq, 1'b0, "vector clears flag");
        wt(1'b0, 1'b0);
        chk(srn, 1'b0, "second expiry resets");
        rel();
        rd(8'h00, 32'h8, "combined reset cause");
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h04, 32'h18);
        bus(1'b1, 8'h04, 32'h00);
        $display("test combined done");
        aon <= 1'b1;
        bus(1'b1, 8'h04, 32'h40);
        rd(8'h04, 32'h08, "fuse holds reset mode");
        wt(1'b0, 1'b0);
        chk(srn, 1'b0, "always-on expiry resets");
        aon <= 1'b0;
        $display("test always-on done");
        print_verdict();
    end
endmodule
